// ==== hw/pdm_mic_defs.svh ====
`ifndef PDM_MIC_DEFS_SVH
`define PDM_MIC_DEFS_SVH

// ****************************************************************
// Clock rates
// ****************************************************************
`define PDM_SYS_CLK_HZ   64'd250000000
`define PDM_BIT_CLK_HZ   64'd2400000
`define PDM_NCO_W        16
// Phase step per system cycle; two carries make one bit clock period
`define PDM_NCO_STEP     ((64'd2 * `PDM_BIT_CLK_HZ * 64'd65536) / `PDM_SYS_CLK_HZ)
// System cycles that the link domain reset request outlasts rst
`define PDM_RST_HOLD     6'd32

// ****************************************************************
// Decimation filter
// ****************************************************************
`define PDM_CIC_W        26
`define PDM_SAMPLE_W     16
`define PDM_DEC_W        9
`define PDM_DECIM_LOW    9'd300
`define PDM_DECIM_HIGH   9'd150
`define PDM_SHIFT_LOW    10
`define PDM_SHIFT_HIGH   7
`define PDM_CHANNELS     2

`endif

// ==== hw/pdm_mic_pkg.sv ====
`include "pdm_mic_defs.svh"

package pdm_mic_pkg;

  typedef logic signed [`PDM_CIC_W-1:0]    acc_t;
  typedef logic [2:0][`PDM_CIC_W-1:0]      cic_stages_t;
  typedef logic signed [`PDM_SAMPLE_W-1:0] sample_t;
  typedef logic [2*`PDM_SAMPLE_W-1:0]      sample_pair_t;

  typedef struct packed {
    cic_stages_t delays;
    acc_t        result;
  } comb_result_t;

  typedef enum logic {
    SRC_MIC,
    SRC_AUX
  } source_t;

endpackage

// ==== hw/pdm_pair_buffer.sv ====
`timescale 1ns/1ps
`default_nettype none

module pdm_pair_buffer (
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic                       clkEn,
  input  wire logic                       inValid,
  output var  logic                       inReady,
  input  wire pdm_mic_pkg::sample_pair_t  inData,
  output var  logic                       outValid,
  input  wire logic                       outReady,
  output var  pdm_mic_pkg::sample_pair_t  outData
);
  import pdm_mic_pkg::*;

  // ****************************************************************
  // Two entries: output register plus skid register
  // ****************************************************************
  typedef struct packed {
    logic         outValid;
    sample_pair_t outData;
    logic         skidValid;
    sample_pair_t skidData;
    logic         inReady;
  } buf_state_t;

  buf_state_t s;
  buf_state_t next_s;

  always_comb
  begin
    next_s = s;
    if (s.outValid && outReady)
    begin
      next_s.outValid  = s.skidValid;
      next_s.outData   = s.skidData;
      next_s.skidValid = 1'b0;
    end
    if (inValid && s.inReady)
    begin
      if (!next_s.outValid)
      begin
        next_s.outValid = 1'b1;
        next_s.outData  = inData;
      end
      else
      begin
        next_s.skidValid = 1'b1;
        next_s.skidData  = inData;
      end
    end
    next_s.inReady = !next_s.skidValid;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s         <= '0;
      s.inReady <= 1'b1;
    end
    else if (clkEn)
    begin
      s <= next_s;
    end
  end

  assign inReady  = s.inReady;
  assign outValid = s.outValid;
  assign outData  = s.outData;

endmodule // pdm_pair_buffer

`default_nettype wire

// ==== hw/pdm_microphone_front_end.sv ====
`timescale 1ns/1ps
`default_nettype none

module pdm_microphone_front_end (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  clkEn,
  output var  logic                  micClk,
  input  wire logic                  linkClk,
  input  wire logic [1:0]            micData,
  input  wire logic                  captureOnFall,
  input  wire logic                  rateHigh,
  input  wire pdm_mic_pkg::source_t  srcSel,
  input  wire logic [1:0]            auxBit,
  input  wire logic                  auxBitValid,
  output var  logic                  sampleValid,
  input  wire logic                  sampleReady,
  output var  pdm_mic_pkg::sample_t  sampleLeft,
  output var  pdm_mic_pkg::sample_t  sampleRight,
  output var  logic                  overrun
);
  import pdm_mic_pkg::*;

  // ****************************************************************
  // Filter arithmetic
  // ****************************************************************
  function automatic cic_stages_t cic_integrate(cic_stages_t st, logic bitIn);
    acc_t x;
    acc_t i0;
    acc_t i1;
    acc_t i2;
    x  = bitIn ? acc_t'(1) : acc_t'(-1);
    i0 = acc_t'(st[0]) + x;
    i1 = acc_t'(st[1]) + i0;
    i2 = acc_t'(st[2]) + i1;
    return {i2, i1, i0};
  endfunction

  function automatic comb_result_t cic_comb(acc_t inVal, cic_stages_t dl);
    comb_result_t r;
    acc_t c0;
    acc_t c1;
    c0 = inVal - acc_t'(dl[0]);
    c1 = c0 - acc_t'(dl[1]);
    r.result = c1 - acc_t'(dl[2]);
    r.delays = {c1, c0, inVal};
    return r;
  endfunction

  function automatic sample_t scale(acc_t v, logic high);
    acc_t sh;
    sh = high ? (v >>> `PDM_SHIFT_HIGH) : (v >>> `PDM_SHIFT_LOW);
    return sh[`PDM_SAMPLE_W-1:0];
  endfunction

  function automatic logic [`PDM_DEC_W-1:0] decim_ratio(logic high);
    return high ? `PDM_DECIM_HIGH : `PDM_DECIM_LOW;
  endfunction

  // ****************************************************************
  // Link domain reset
  // ****************************************************************
  typedef struct packed {
    logic rst1;
    logic rst2;
  } link_rst_t;

  link_rst_t lr;
  link_rst_t next_lr;
  logic      linkRstReq;

  always_comb
  begin
    next_lr      = lr;
    next_lr.rst1 = linkRstReq;
    next_lr.rst2 = lr.rst1;
  end

  always_ff @(posedge linkClk)
  begin
    lr <= next_lr;
  end

  // ****************************************************************
  // Falling edge capture
  // ****************************************************************
  typedef struct packed {
    logic [1:0] bits;
  } link_fall_t;

  link_fall_t lf;
  link_fall_t next_lf;

  always_comb
  begin
    next_lf      = lf;
    next_lf.bits = micData;
  end

  always_ff @(negedge linkClk)
  begin
    lf <= next_lf;
  end

  // ****************************************************************
  // Rising edge capture and word hand-off
  // ****************************************************************
  typedef struct packed {
    logic [1:0] rise1;
    logic [1:0] rise2;
    logic [1:0] fall2;
    logic       edge1;
    logic       edge2;
    logic [1:0] word;
    logic       toggle;
  } link_state_t;

  link_state_t ls;
  link_state_t next_ls;

  always_comb
  begin
    next_ls       = ls;
    next_ls.rise1 = micData;
    next_ls.rise2 = ls.rise1;
    next_ls.fall2 = lf.bits;
    next_ls.edge1 = captureOnFall;
    next_ls.edge2 = ls.edge1;
    // Edge choice applies once its select is synchronised
    next_ls.word   = ls.edge2 ? ls.fall2 : ls.rise2;
    next_ls.toggle = !ls.toggle;
  end

  always_ff @(posedge linkClk)
  begin
    if (lr.rst2)
    begin
      ls <= '0;
    end
    else
    begin
      ls <= next_ls;
    end
  end

  // ****************************************************************
  // System domain state
  // ****************************************************************
  typedef struct packed {
    logic [`PDM_NCO_W-1:0]           nco;
    logic                            bitClk;
    logic [2:0]                      togSync;
    cic_stages_t [`PDM_CHANNELS-1:0] integ;
    cic_stages_t [`PDM_CHANNELS-1:0] combDl;
    logic [`PDM_DEC_W-1:0]           decCnt;
    logic                            rateSel;
    logic                            pendValid;
    sample_pair_t                    pendData;
    logic                            overrun;
    logic [5:0]                      rstHold;
    logic                            linkRst;
  } sys_state_t;

  sys_state_t s;
  sys_state_t next_s;

  logic                   bufInReady;
  logic                   bufOutValid;
  sample_pair_t           bufOutData;
  logic                   bitEvent;
  logic [1:0]             bitsIn;
  logic [`PDM_NCO_W:0]    ncoSum;
  logic [`PDM_DEC_W-1:0]  ratio;
  comb_result_t           combL;
  comb_result_t           combR;

  always_comb
  begin
    next_s = s;
    next_s.overrun = 1'b0;

    // Link domain reset request outlasts several link clock periods
    next_s.linkRst = (s.rstHold != 6'h0);
    if (s.rstHold != 6'h0)
    begin
      next_s.rstHold = s.rstHold - 6'h1;
    end

    // Bit clock from a phase accumulator
    ncoSum = {1'b0, s.nco} + {1'b0, `PDM_NCO_W'(`PDM_NCO_STEP)};
    next_s.nco = ncoSum[`PDM_NCO_W-1:0];
    if (ncoSum[`PDM_NCO_W])
    begin
      next_s.bitClk = !s.bitClk;
    end

    // Word arrival from the link domain
    next_s.togSync = {s.togSync[1], s.togSync[0], ls.toggle};
    if (srcSel == SRC_AUX)
    begin
      bitEvent = auxBitValid;
      bitsIn   = auxBit;
    end
    else
    begin
      bitEvent = s.togSync[2] ^ s.togSync[1];
      bitsIn   = ls.word;
    end

    // Hand pending pair to the buffer
    if (s.pendValid && bufInReady)
    begin
      next_s.pendValid = 1'b0;
    end

    // Frame count, integrators and, at frame end, the comb stages
    ratio = decim_ratio(s.rateSel);
    combL = '0;
    combR = '0;
    if (bitEvent)
    begin
      // Integrate each channel on every bit
      for (int ch = 0; ch < `PDM_CHANNELS; ch++)
      begin
        next_s.integ[ch] = cic_integrate(s.integ[ch], bitsIn[ch]);
      end
      // Count bits toward the frame end
      next_s.decCnt = s.decCnt + `PDM_DEC_W'(1);
      if (s.decCnt == ratio - `PDM_DEC_W'(1))
      begin
        next_s.decCnt  = '0;
        // Rate change takes effect from the next frame
        next_s.rateSel = rateHigh;
        combL = cic_comb(acc_t'(next_s.integ[0][2]), s.combDl[0]);
        combR = cic_comb(acc_t'(next_s.integ[1][2]), s.combDl[1]);
        next_s.combDl[0] = combL.delays;
        next_s.combDl[1] = combR.delays;
        // Pending slot still full: the pair is dropped
        if (next_s.pendValid)
        begin
          next_s.overrun = 1'b1;
        end
        else
        begin
          next_s.pendValid = 1'b1;
          next_s.pendData  = {scale(combR.result, s.rateSel),
                              scale(combL.result, s.rateSel)};
        end
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s         <= '0;
      s.rstHold <= `PDM_RST_HOLD;
      s.linkRst <= 1'b1;
    end
    else if (clkEn)
    begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Output buffer
  // ****************************************************************
  pdm_pair_buffer u_buffer (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .clkEn    (clkEn),
    .inValid  (s.pendValid),
    .inReady  (bufInReady),
    .inData   (s.pendData),
    .outValid (bufOutValid),
    .outReady (sampleReady),
    .outData  (bufOutData)
  );

  // ****************************************************************
  // Outputs and link reset request
  // ****************************************************************
  assign linkRstReq  = s.linkRst;
  assign micClk      = s.bitClk;
  assign overrun     = s.overrun;
  assign sampleValid = bufOutValid;
  assign sampleLeft  = bufOutData[`PDM_SAMPLE_W-1:0];
  assign sampleRight = bufOutData[2*`PDM_SAMPLE_W-1:`PDM_SAMPLE_W];

endmodule // pdm_microphone_front_end

`default_nettype wire

// ==== tb/pdm_mic_fe_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module pdm_mic_fe_sva (
  input wire logic                 sys_clk,
  input wire logic                 rst,
  input wire logic                 clkEn,
  input wire logic                 micClk,
  input wire logic                 sampleValid,
  input wire logic                 sampleReady,
  input wire pdm_mic_pkg::sample_t sampleLeft,
  input wire pdm_mic_pkg::sample_t sampleRight,
  input wire logic                 overrun
);
  import pdm_mic_pkg::*;
  // ****
  // Half period counter
  // ****
  logic        lastClk;
  logic        seenEdge;
  logic [15:0] halfCnt;
  wire  logic  toggle;
  assign toggle = micClk != lastClk;
  always_ff @(posedge sys_clk)
  begin
    lastClk <= micClk;
    if (rst)
    begin
      halfCnt  <= 16'h0;
      seenEdge <= 1'b0;
    end
    else if (toggle)
    begin
      halfCnt  <= 16'h0;
      seenEdge <= 1'b1;
    end
    else if (clkEn)
      halfCnt <= halfCnt + 16'h1;
  end
  // ****
  // Properties
  // ****
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  half_max_a: assert property (halfCnt <= 16'h38)
    else $error("bit clock half period too long");
  half_min_a: assert property (toggle && seenEdge |-> halfCnt >= 16'h30)
    else $error("bit clock half period too short");
  reset_quiet_a: assert property ($past(rst) |-> !micClk && !sampleValid && !overrun)
    else $error("outputs not quiet after reset");
  hold_pair_a: assert property (sampleValid && !(sampleReady && clkEn) |=>
    sampleValid && $stable(sampleLeft) && $stable(sampleRight))
    else $error("sample pair not held");
  freeze_en_a: assert property (!clkEn |=> $stable(micClk) && $stable(sampleValid))
    else $error("state moved with enable low");
  overrun_busy_a: assert property (overrun |-> sampleValid)
    else $error("overrun with empty output");
  overrun_gap_a: assert property (overrun && clkEn |=> !overrun [*8])
    else $error("overrun pulses too close");
  cover property (sampleValid && sampleReady && clkEn);
  cover property (overrun);
  cover property (toggle && seenEdge);
endmodule // pdm_mic_fe_sva
bind pdm_microphone_front_end pdm_mic_fe_sva u_sva (.sys_clk(sys_clk), .rst(rst),
  .clkEn(clkEn), .micClk(micClk), .sampleValid(sampleValid), .sampleReady(sampleReady),
  .sampleLeft(sampleLeft), .sampleRight(sampleRight), .overrun(overrun));
`default_nettype wire

// ==== tb/pdm_mic_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pdm_mic_model (
  input  wire logic       linkClk,
  input  wire logic       captureOnFall,
  input  wire logic [1:0] level,
  output var  logic [1:0] micData
);
  // ****
  // Data launched on the edge away from capture
  // ****
  initial micData = 2'h0;
  always @(linkClk)
  begin
    if (linkClk === captureOnFall)
      micData <= level;
  end
endmodule // pdm_mic_model
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pdm_mic_pkg::*;
  // ****
  // Signals
  // ****
  logic       sys_clk = 1'b0;
  logic       linkClk = 1'b0;
  logic       rst = 1'b1;
  logic       clkEn = 1'b1;
  logic       micClk;
  logic [1:0] micData;
  logic [1:0] micLvl = 2'h0;
  logic       captureOnFall = 1'b0;
  logic       rateHigh = 1'b0;
  source_t    srcSel = SRC_MIC;
  logic [1:0] auxBit = 2'h0;
  logic       auxBitValid = 1'b0;
  logic       auxMode = 1'b0;
  logic       sampleValid;
  logic       sampleReady = 1'b1;
  sample_t    sampleLeft;
  sample_t    sampleRight;
  sample_t    gotL;
  sample_t    gotR;
  logic       overrun;
  int         nPairs = 0;
  int         ovCnt = 0;
  int         cyc = 0;
  int         failures = 0;
  int         total_checks = 0;
  pdm_microphone_front_end u_dut (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
    .micClk(micClk), .linkClk(linkClk), .micData(micData), .captureOnFall(captureOnFall),
    .rateHigh(rateHigh), .srcSel(srcSel), .auxBit(auxBit), .auxBitValid(auxBitValid),
    .sampleValid(sampleValid), .sampleReady(sampleReady), .sampleLeft(sampleLeft),
    .sampleRight(sampleRight), .overrun(overrun));
  pdm_mic_model u_mic (.linkClk(linkClk), .captureOnFall(captureOnFall), .level(micLvl),
    .micData(micData));
  // ****
  // Clocks, drivers, monitors
  // ****
  always #2 sys_clk = ~sys_clk;
  initial
  begin
    #7;
    forever #24 linkClk = ~linkClk;
  end
  always @(posedge sys_clk)
  begin
    auxBitValid <= auxMode && ($urandom % 2 == 1);
    clkEn       <= !auxMode || ($urandom % 8 != 0);
    if (sampleValid && sampleReady && clkEn)
    begin
      gotL   <= sampleLeft;
      gotR   <= sampleRight;
      nPairs <= nPairs + 1;
    end
    if (overrun)
      ovCnt <= ovCnt + 1;
    cyc = cyc + 1;
    if (cyc == 60000)
    begin
      failures++;
      close_out;
    end
  end
  // ****
  // Tasks
  // ****
  function automatic sample_t expect_of(input logic hi, input logic one);
    int n;
    int v;
    n = hi ? 150 : 300;
    v = one ? (n * n * n) : -(n * n * n);
    return sample_t'(v >>> (hi ? 7 : 10));
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_pairs(input int n);
    int target;
    target = nPairs + n;
    while (nPairs < target)
      @(posedge sys_clk);
  endtask
  task automatic close_out;
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ****
  // Sequence
  // ****
  initial
  begin
    void'($urandom(32'h55695911));
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      captureOnFall <= i[0];
      rateHigh      <= i[0];
      micLvl        <= (i == 0) ? 2'h1 : 2'($urandom);
      wait_pairs(6);
      chk(gotL, expect_of(rateHigh, micLvl[0]));
      chk(gotR, expect_of(rateHigh, micLvl[1]));
    end
    srcSel      <= SRC_AUX;
    auxBit      <= 2'h2;
    auxMode     <= 1'b1;
    sampleReady <= 1'b0;
    while (ovCnt == 0)
      @(posedge sys_clk);
    sampleReady <= 1'b1;
    wait_pairs(6);
    chk(gotL, expect_of(1'b1, 1'b0));
    chk(gotR, expect_of(1'b1, 1'b1));
    chk(16'(ovCnt != 0), 16'h1);
    close_out;
  end
endmodule // testbench
`default_nettype wire
